// ---- design/rsc_pkg.sv ----
package rsc_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [7:0] REG_LVS = 8'h00;
  localparam logic [7:0] REG_BGB = 8'h04;
  localparam logic [7:0] REG_CAUSE = 8'h08;
  localparam logic [7:0] REG_WDC = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  // low voltage select codes and reset value
  localparam logic [7:0] LVS_ENA = 8'h5A;
  localparam logic [7:0] LVS_DIS = 8'hA5;
  localparam logic [7:0] LVS_RST = 8'h5A;
  // watchdog control codes, layout and reset value
  localparam logic [7:0] WDC_RST = 8'h53;
  localparam logic [4:0] WD_ENA = 5'h0A;
  localparam logic [4:0] WD_DIS = 5'h15;
  localparam logic [3:0] WD_MIN_EXP = 4'h8;
  // field positions
  localparam int BGB_BIT = 3;
  localparam int CAUSE_BROWN = 2;
  localparam int CAUSE_BADLV = 1;
  localparam int CAUSE_BADWD = 0;
  localparam int STAT_TO = 0;
  localparam int STAT_PD = 1;
  localparam int STAT_LVD = 2;
  // timing, soft and brownout delays in low speed clock periods, reset hold in clk cycles
  localparam logic [3:0] SRESET_TICKS = 4'h8;
  localparam logic [3:0] QUALIFY_TICKS = 4'h4;
  localparam int SYS_CLK_MHZ = 40;
  localparam int RST_HOLD_NS = 100;
  localparam logic [2:0] RST_HOLD_CYC = 3'((RST_HOLD_NS * SYS_CLK_MHZ + 999) / 1000);
  // reset sequencer
  typedef enum logic {ST_RUN, ST_HOLD} rsc_state_t;
endpackage

// ---- design/rsc_reset_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl import rsc_pkg::*; (
  // system
  input wire logic clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core events
  input wire logic clear_watchdog_instruction_i,
  input wire logic halt_i,
  input wire logic low_power_i,
  // analog and low speed clock
  input wire logic lv_low_i,
  input wire logic low_speed_rc_clock_i,
  // reset outputs to core
  output logic core_rst_o,
  output logic cold_o,
  output logic pc_sp_clear_o,
  // status and analog enables
  output logic lvd_enable_o,
  output logic bandgap_en_o,
  output logic timeout_flag_o,
  output logic powerdown_flag_o
);
  // input synchronisers
  logic rc_s1_r;
  logic rc_s2_r;
  logic rc_s3_r;
  logic lv_s1_r;
  logic lv_s2_r;

  // decoded events and bus strobes
  logic tick;
  logic acc;
  logic wr;
  logic [31:0] rdata;

  // software visible registers and flags
  logic [7:0] lvs_r;
  logic bgb_r;
  logic [7:0] wdc_r;
  logic [2:0] cause_r;
  logic [2:0] cause_set;
  logic [2:0] cause_clr;
  logic to_r;
  logic pd_r;

  // reset sequencer and registered outputs
  rsc_state_t state_r;
  logic [2:0] hold_cnt_r;
  logic core_rst_r;
  logic cold_r;
  logic pc_sp_r;
  logic lvd_en_r;
  logic bg_r;

  // watchdog and delay counters
  logic [15:0] wd_cnt_r;
  logic [3:0] soft_cnt_r;
  logic [3:0] qual_cnt_r;
  logic soft_wd_r;
  logic soft_lv_r;

  // combinational decode
  logic wd_en;
  logic wd_bad;
  logic lv_bad;
  logic lvd_on;
  logic wd_ovf;
  logic soft_fire;
  logic brown_fire;
  logic full_fire;
  logic wake_fire;
  logic running;

  // low speed clock: two flop synchroniser, third flop only for edge detect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      rc_s3_r <= 1'b0;
    end else begin
      rc_s1_r <= low_speed_rc_clock_i;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
    end
  end

  // detector output: two flop synchroniser, level used directly
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lv_s1_r <= 1'b0;
      lv_s2_r <= 1'b0;
    end else begin
      lv_s1_r <= lv_low_i;
      lv_s2_r <= lv_s1_r;
    end
  end

  // low speed tick from the synchronised rc clock, one clk wide
  assign tick = rc_s2_r & ~rc_s3_r; // one low speed period
  assign running = (state_r == ST_RUN);

  // guarded code checks, anything but the two codes arms a soft reset
  assign wd_en = (wdc_r[7:3] == WD_ENA);
  assign wd_bad = (wdc_r[7:3] != WD_ENA) && (wdc_r[7:3] != WD_DIS);
  assign lv_bad = (lvs_r != LVS_ENA) && (lvs_r != LVS_DIS);
  assign lvd_on = (lvs_r == LVS_ENA) & ~low_power_i;

  // watchdog overflow taps the counter bit of the selected period
  assign wd_ovf = wd_cnt_r[WD_MIN_EXP | {1'b0, wdc_r[2:0]}];

  // reset triggers, only armed while the core is out of reset
  assign soft_fire = running & tick & (soft_wd_r | soft_lv_r)
                     & (soft_cnt_r == SRESET_TICKS);
  assign brown_fire = running & tick & lv_s2_r & lvd_on
                      & (qual_cnt_r == QUALIFY_TICKS);
  assign full_fire = running & ((wd_ovf & ~low_power_i) | soft_fire | brown_fire);
  assign wake_fire = running & wd_ovf & low_power_i;

  // wishbone handshake: ack one cycle after request
  // the ~ack term keeps a held strobe from being taken twice
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = acc & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  // read mux, unmapped reads as zero
  // only the low byte carries data, upper bits always read zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (wb_adr_i)
      REG_LVS: rdata[7:0] = lvs_r;
      REG_BGB: rdata[BGB_BIT] = bgb_r;
      REG_CAUSE: rdata[2:0] = cause_r;
      REG_WDC: rdata[7:0] = wdc_r;
      REG_STAT: begin
        rdata[STAT_TO] = to_r;
        rdata[STAT_PD] = pd_r;
        rdata[STAT_LVD] = lvd_en_r;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (acc) begin
      wb_dat_o <= rdata;
    end
  end

  // low voltage select: kept on brownout, restored on power-on and other full resets
  // a bus write on the same edge as a full reset is dropped, brownout included
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lvs_r <= LVS_RST;
    end else if (full_fire) begin
      if (!brown_fire) begin
        lvs_r <= LVS_RST;
      end
    end else if (wr && wb_adr_i == REG_LVS) begin
      lvs_r <= wb_dat_i[7:0];
    end
  end

  // watchdog control, reinitialised by every full reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdc_r <= WDC_RST;
    end else if (full_fire) begin
      wdc_r <= WDC_RST;
    end else if (wr && wb_adr_i == REG_WDC) begin
      wdc_r <= wb_dat_i[7:0];
    end
  end

  // bandgap buffer bit, reinitialised by every full reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bgb_r <= 1'b0;
    end else if (full_fire) begin
      bgb_r <= 1'b0;
    end else if (wr && wb_adr_i == REG_BGB) begin
      bgb_r <= wb_dat_i[BGB_BIT];
    end
  end

  // sticky reset cause flags, hardware set wins over software clear
  // a clear needs a zero in the written bit, writing ones leaves a flag alone
  assign cause_set[CAUSE_BROWN] = brown_fire;
  assign cause_set[CAUSE_BADLV] = soft_fire & soft_lv_r;
  assign cause_set[CAUSE_BADWD] = soft_fire & soft_wd_r;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cause
      assign cause_clr[gi] = wr && (wb_adr_i == REG_CAUSE) && !wb_dat_i[gi];
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cause_r[gi] <= 1'b0;
        end else begin
          cause_r[gi] <= cause_set[gi] | (cause_r[gi] & ~cause_clr[gi]);
        end
      end
    end
  endgenerate

  // timeout flag: set by any watchdog overflow, cleared by clear or halt
  // an overflow in the same cycle as a clear still sets the flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      to_r <= 1'b0;
    end else if (running && wd_ovf) begin
      to_r <= 1'b1;
    end else if (clear_watchdog_instruction_i || halt_i) begin
      to_r <= 1'b0;
    end
  end

  // powerdown flag: set by halt, cleared by clear instruction
  // halt and the wake reset both leave the flag high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pd_r <= 1'b0;
    end else if (halt_i || wake_fire) begin
      pd_r <= 1'b1;
    end else if (clear_watchdog_instruction_i) begin
      pd_r <= 1'b0;
    end
  end

  // watchdog counter on low speed ticks
  // held at zero while the enable code is bad or the core is held in reset;
  // an overflow restarts the count so a wake reset leaves it running
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wd_cnt_r <= 16'h0000;
    end else if (clear_watchdog_instruction_i || halt_i || wd_bad || !running || wd_ovf) begin
      wd_cnt_r <= 16'h0000;
    end else if (tick && wd_en) begin
      wd_cnt_r <= wd_cnt_r + 16'h0001;
    end
  end

  // guarded code soft reset: latch cause, then count the delay
  // a pending soft reset stays armed even if a valid code is written back
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      soft_wd_r <= 1'b0;
      soft_lv_r <= 1'b0;
      soft_cnt_r <= 4'h0;
    end else if (!running) begin
      soft_wd_r <= 1'b0;
      soft_lv_r <= 1'b0;
      soft_cnt_r <= 4'h0;
    end else begin
      if (wd_bad) begin
        soft_wd_r <= 1'b1;
      end
      if (lv_bad) begin
        soft_lv_r <= 1'b1;
      end
      if (tick && (soft_wd_r || soft_lv_r)) begin
        soft_cnt_r <= soft_cnt_r + 4'h1;
      end
    end
  end

  // brownout qualification, restarts whenever supply recovers
  // the counter saturates at the limit and fires on the next tick, so a
  // low supply must outlast the qualify time to cause a reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      qual_cnt_r <= 4'h0;
    end else if (!lv_s2_r || !lvd_on || !running) begin
      qual_cnt_r <= 4'h0;
    end else if (tick && qual_cnt_r != QUALIFY_TICKS) begin
      qual_cnt_r <= qual_cnt_r + 4'h1;
    end
  end

  // reset sequencer, holds the core in reset for a few cycles
  // cold start only drops at the end of the power-on hold and only a power-on
  // reset raises it again; the core model loads the same state on any full reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_HOLD;
      hold_cnt_r <= 3'(RST_HOLD_CYC - 3'h1);
      core_rst_r <= 1'b1;
      cold_r <= 1'b1;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (full_fire) begin
            state_r <= ST_HOLD;
            hold_cnt_r <= 3'(RST_HOLD_CYC - 3'h1);
            core_rst_r <= 1'b1;
          end
        end
        ST_HOLD: begin
          if (hold_cnt_r == 3'h0) begin
            state_r <= ST_RUN;
            core_rst_r <= 1'b0;
            cold_r <= 1'b0;
          end else begin
            hold_cnt_r <= hold_cnt_r - 3'h1;
          end
        end
        default: begin
          state_r <= ST_HOLD;
          hold_cnt_r <= 3'(RST_HOLD_CYC - 3'h1);
          core_rst_r <= 1'b1;
        end
      endcase
    end
  end

  // registered pulses and enables toward core and analog
  // wake pulse is one cycle wide since the overflow restarts the counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_sp_r <= 1'b0;
      lvd_en_r <= 1'b0;
      bg_r <= 1'b0;
    end else begin
      pc_sp_r <= wake_fire;
      lvd_en_r <= lvd_on;
      bg_r <= lvd_on | bgb_r;
    end
  end

  // outputs straight from their flops
  assign core_rst_o = core_rst_r;
  assign cold_o = cold_r;
  assign pc_sp_clear_o = pc_sp_r;
  assign lvd_enable_o = lvd_en_r;
  assign bandgap_en_o = bg_r;
  assign timeout_flag_o = to_r;
  assign powerdown_flag_o = pd_r;
endmodule
`default_nettype wire

// ---- dv/rsc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsc_core_model (
  // clock and reset requests
  input wire logic clk,
  input wire logic core_rst,
  input wire logic cold,
  input wire logic pc_sp_clear,
  // visible core state
  output logic [7:0] pc_r,
  output logic [1:0] sp_r,
  output logic [7:0] port_a_r,
  output logic ints_on_r
);
  // core state; a full reset outranks the wake reset
  always_ff @(posedge clk) begin
    if (core_rst || cold) begin
      pc_r <= 8'h00;
      sp_r <= 2'h0;
      port_a_r <= 8'hFF;
      ints_on_r <= 1'b0;
    end else if (pc_sp_clear) begin
      pc_r <= 8'h00;
      sp_r <= 2'h0;
    end else begin
      pc_r <= pc_r + 8'h01;
      if (pc_r == 8'h08) sp_r <= sp_r + 2'h1;
      if (pc_r == 8'h10) port_a_r <= 8'h3C;
      if (pc_r == 8'h20) ints_on_r <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- dv/rsc_reset_ctrl_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl_checker (
  // system
  input wire logic clk,
  input wire logic rstn,
  // core events
  input wire logic clear_watchdog_instruction_i,
  input wire logic halt_i,
  input wire logic low_power_i,
  // block outputs
  input wire logic core_rst_o,
  input wire logic cold_o,
  input wire logic pc_sp_clear_o,
  input wire logic lvd_enable_o,
  input wire logic bandgap_en_o,
  input wire logic timeout_flag_o,
  input wire logic powerdown_flag_o
);
  // one domain, paused while power-on reset is low
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_por_hold: assert property ($rose(rstn) |-> (core_rst_o && cold_o)[*4] ##1 !cold_o)
    else $error("power-on hold length wrong");
  a_por_flags: assert property ($rose(rstn) |-> !timeout_flag_o && !powerdown_flag_o)
    else $error("flags not cleared by power-on");
  a_halt_flags: assert property (halt_i |=> powerdown_flag_o && !timeout_flag_o)
    else $error("halt flags wrong");
  a_clr_flags: assert property (clear_watchdog_instruction_i |=> !powerdown_flag_o && !timeout_flag_o)
    else $error("clear flags wrong");
  a_sleep_off: assert property (low_power_i |=> !lvd_enable_o)
    else $error("detector on in low power");
  a_bandgap_on: assert property (lvd_enable_o |-> bandgap_en_o)
    else $error("bandgap off with detector on");
  a_sleep_wake: assert property (
    pc_sp_clear_o |-> !core_rst_o ##1 (!pc_sp_clear_o && timeout_flag_o && powerdown_flag_o))
    else $error("wake reset wrong");
  a_run_reset: assert property (
    $rose(timeout_flag_o) && !low_power_i |-> ##[0:2] core_rst_o)
    else $error("run timeout gave no reset");
  // main scenarios reached
  c_wake: cover property (pc_sp_clear_o);
  c_reset: cover property ($rose(core_rst_o));
  c_halt: cover property (halt_i);
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_checker chk_i (.clk, .rstn, .clear_watchdog_instruction_i, .halt_i,
  .low_power_i, .core_rst_o, .cold_o, .pc_sp_clear_o, .lvd_enable_o, .bandgap_en_o,
  .timeout_flag_o, .powerdown_flag_o);
`default_nettype wire

// ---- dv/rsc_reset_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl_tb;
  import rsc_pkg::*;
  logic clk, rstn, cyc, stb, we, clr, halt, lp, lv, rc, ack, crst, cold, pcsp, lvde, bge;
  logic tof, powerdown_flag, ion;
  logic [7:0] adr, pc, pa;
  logic [31:0] wd, rd, d;
  logic [1:0] sp, lc;
  int n_errors, check_count, n;
  // block and the core behind it
  rsc_reset_ctrl DUT (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .clear_watchdog_instruction_i(clr), .halt_i(halt), .low_power_i(lp), .lv_low_i(lv),
    .low_speed_rc_clock_i(rc), .core_rst_o(crst), .cold_o(cold), .pc_sp_clear_o(pcsp),
    .lvd_enable_o(lvde), .bandgap_en_o(bge), .timeout_flag_o(tof), .powerdown_flag_o(powerdown_flag));
  rsc_core_model core (.clk(clk), .core_rst(crst), .cold(cold), .pc_sp_clear(pcsp),
    .pc_r(pc), .sp_r(sp), .port_a_r(pa), .ints_on_r(ion));
  // system clock, slow tick every four cycles
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    lc <= lc + 2'h1;
    rc <= lc[1];
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= v;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    d = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic ev(input logic c, input logic h);
    @(posedge clk);
    clr <= c;
    halt <= h;
    @(posedge clk);
    clr <= 1'b0;
    halt <= 1'b0;
  endtask
  // wait for a reset or the limit, supply recovers after either
  task automatic wfor(input logic s, input int hi);
    n = 0;
    while ((s ? pcsp : crst) !== 1'b1 && n < hi) begin
      @(posedge clk);
      n++;
    end
    lv <= 1'b0;
    while (!s && crst === 1'b1) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic t_regs;
    bus(0, REG_LVS, 0);
    chk(d, 32'h5A);
    bus(0, REG_STAT, 0);
    chk(d, 32'h4);
    bus(1, 8'h20, 32'h77);
    bus(0, 8'h20, 0);
    chk(d, 0);
    bus(1, REG_BGB, 32'hFF);
    bus(0, REG_BGB, 0);
    chk(d, 32'h08);
    bus(1, REG_LVS, LVS_DIS);
    bus(0, REG_STAT, 0);
    chk({d[2], lvde, bge}, 3'b001);
    bus(1, REG_BGB, 0);
    bus(1, REG_LVS, LVS_ENA);
    lp <= 1'b1;
    bus(0, REG_STAT, 0);
    chk({d[2], lvde, bge}, 3'b000);
    lp <= 1'b0;
    bus(0, REG_STAT, 0);
    chk({d[2], bge}, 2'b11);
    ev(0, 1);
    @(posedge clk);
    chk({tof, powerdown_flag}, 2'b01);
    ev(1, 0);
    @(posedge clk);
    chk({tof, powerdown_flag}, 2'b00);
    $display("done: registers and events");
  endtask
  task automatic t_wdt;
    ev(1, 0);
    bus(1, REG_WDC, 32'h50);
    ev(0, 1);
    wfor(0, 1100);
    chk(n > 1000 && n < 1100, 1);
    chk({tof, powerdown_flag, pc, sp, pa}, {2'b11, 8'h00, 2'h0, 8'hFF});
    chk(ion, 1'b0);
    bus(0, REG_WDC, 0);
    chk(d, WDC_RST);
    ev(1, 0);
    bus(1, REG_WDC, 32'h50);
    ev(0, 1);
    lp <= 1'b1;
    wfor(1, 1100);
    chk(n > 1000 && n < 1100, 1);
    @(posedge clk);
    chk({tof, powerdown_flag, crst, pc, sp, pa}, {3'b110, 8'h00, 2'h0, 8'h3C});
    chk(ion, 1'b1);
    lp <= 1'b0;
    bus(0, REG_WDC, 0);
    chk(d, 32'h50);
    bus(1, REG_WDC, WDC_RST);
    ev(1, 0);
    $display("done: watchdog");
  endtask
  task automatic t_soft;
    for (int i = 0; i < 2; i++) begin
      bus(1, i ? REG_LVS : REG_WDC, 32'h33);
      wfor(0, 60);
      chk(n > 28 && n < 50, 1);
      bus(1, REG_CAUSE, 32'hFF);
      bus(0, REG_CAUSE, 0);
      chk(d, i ? 32'h2 : 32'h1);
      bus(1, REG_CAUSE, 0);
      bus(0, REG_CAUSE, 0);
      chk(d, 0);
      bus(0, REG_LVS, 0);
      chk(d, LVS_RST);
    end
    $display("done: soft resets");
  endtask
  task automatic t_brown;
    ev(0, 1);
    lv <= 1'b1;
    wfor(0, 8);
    wfor(0, 100);
    chk(n, 100);
    lp <= 1'b1;
    lv <= 1'b1;
    wfor(0, 100);
    chk(n, 100);
    lp <= 1'b0;
    lv <= 1'b1;
    wfor(0, 60);
    chk(n > 12 && n < 40, 1);
    chk({tof, powerdown_flag}, 2'b01);
    bus(0, REG_CAUSE, 0);
    chk(d, 32'h4);
    bus(0, REG_LVS, 0);
    chk(d, LVS_ENA);
    $display("done: brownout");
  endtask
  // hang guard
  initial begin
    #500000;
    n_errors++;
    print_verdict();
  end
  initial begin
    {rstn, cyc, stb, we, clr, halt, lp, lv, rc, lc, adr, wd} = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    wfor(0, 0);
    t_regs();
    t_wdt();
    t_soft();
    t_brown();
    print_verdict();
  end
endmodule
`default_nettype wire
